/* File: fieldbus_pkg.sv */
// How it works
// - Default indicator shows standard device health
// - Fixed mode holds one chosen colour
// - Off mode keeps indicator always dark
// - Description holds at most 19 characters
// - Unique name change breaks links; relink
// - Bit rate defaults to 500 kbit/s
// - All participants must share one bit rate
// - New bit rate applies after restart
// - Vendor bus node address defaults to 30
// - Integrator gives every CANopen node distinct address
// - New node address applies after restart
// - Mode standalone, vendor or CANopen; variant default
// - Vendor mode without bus raises lost error
// - Standalone mode raises no bus error
// - Vendor mode goes Operational, sends process data
// - CANopen stays Pre-op until master commands
// - Standalone stays Pre-op, sends no process data
// - Standalone keeps configuration channel working
package fieldbus_pkg;

  // ****************************************
  // Modes and states
  // ****************************************
  typedef enum logic [1:0] {
    MODE_STANDALONE = 2'b00,
    MODE_VENDOR = 2'b01,
    MODE_CANOPEN = 2'b10
  } bus_mode_t;

  typedef enum logic [0:0] {
    NET_PREOP = 1'b0,
    NET_OPERATIONAL = 1'b1
  } net_state_t;

  typedef enum logic [1:0] {
    IND_HEALTH = 2'b00,
    IND_FIXED = 2'b01,
    IND_OFF = 2'b10
  } ind_mode_t;

  typedef enum logic [1:0] {
    LINK_DOWN = 2'b00,
    LINK_UP = 2'b01,
    LINK_RESTORE = 2'b10
  } link_state_t;

  // ****************************************
  // Widths and codes
  // ****************************************
  localparam int MODE_W = 2;
  localparam int RATE_W = 3;
  localparam int ADDR_W = 7;
  localparam int IND_W = 2;
  localparam int COLOUR_W = 3;
  localparam int HEALTH_W = 2;
  localparam int DESC_LEN = 19;
  localparam int IDX_W = 5;
  localparam int CHAR_W = 8;
  localparam int DATA_W = 32;
  localparam int PADDR_W = 8;

  localparam logic [RATE_W-1:0] RATE_125K = 3'h0;
  localparam logic [RATE_W-1:0] RATE_250K = 3'h1;
  localparam logic [RATE_W-1:0] RATE_500K = 3'h2;
  localparam logic [RATE_W-1:0] RATE_1000K = 3'h3;
  localparam logic [RATE_W-1:0] RATE_RESET = RATE_500K;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h1e;

  localparam logic [COLOUR_W-1:0] LED_DARK = 3'h0;
  localparam logic [COLOUR_W-1:0] LED_BLUE = 3'h1;
  localparam logic [COLOUR_W-1:0] LED_GREEN = 3'h2;
  localparam logic [COLOUR_W-1:0] LED_RED = 3'h4;
  localparam logic [COLOUR_W-1:0] LED_YELLOW = 3'h6;
  localparam logic [COLOUR_W-1:0] COLOUR_RESET = LED_GREEN;

  localparam logic [HEALTH_W-1:0] HEALTH_OK = 2'h0;
  localparam logic [HEALTH_W-1:0] HEALTH_MAINT = 2'h1;
  localparam logic [HEALTH_W-1:0] HEALTH_SPEC = 2'h2;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [PADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_CFG = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_UNAME = 8'h08;
  localparam logic [PADDR_W-1:0] OFF_DESC_IDX = 8'h0c;
  localparam logic [PADDR_W-1:0] OFF_DESC_DATA = 8'h10;
  localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h14;
  localparam logic [PADDR_W-1:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [PADDR_W-1:0] OFF_IRQ_MASK = 8'h1c;

  localparam int CTRL_RESTART_BIT = 0;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_RATE_LSB = 4;
  localparam int CFG_ADDR_LSB = 8;
  localparam int CFG_IND_LSB = 16;
  localparam int CFG_COLOUR_LSB = 20;
  localparam int ST_OPER_BIT = 16;
  localparam int ST_PDO_BIT = 17;
  localparam int ST_LOST_BIT = 18;
  localparam int ST_BROKEN_BIT = 19;

  localparam int IRQ_W = 3;
  localparam int IRQ_LOST = 0;
  localparam int IRQ_NAME = 1;
  localparam int IRQ_OPER = 2;
  localparam logic [DATA_W-1:0] UNAME_RESET = 32'h00000000;

endpackage : fieldbus_pkg

/* File: fieldbus_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface fieldbus_link_if;
  logic bus_present;
  logic op_cmd;
  logic relink;
  logic [fieldbus_pkg::RATE_W-1:0] dev_rate;
  logic [fieldbus_pkg::ADDR_W-1:0] dev_addr;
  logic dev_operational;
  logic name_chg;
  logic pdo_valid;
  logic [fieldbus_pkg::DATA_W-1:0] pdo_data;

  modport dev (
    input bus_present, op_cmd, relink,
    output dev_rate, dev_addr, dev_operational, name_chg, pdo_valid, pdo_data
  );
  modport master (
    output bus_present, op_cmd, relink,
    input dev_rate, dev_addr, dev_operational, name_chg, pdo_valid, pdo_data
  );
endinterface : fieldbus_link_if
`default_nettype wire

/* File: status_indicator.sv */
`timescale 1ns/100ps
`default_nettype none
module status_indicator (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Settings and health
  input wire fieldbus_pkg::ind_mode_t ind_mode,
  input wire logic [fieldbus_pkg::COLOUR_W-1:0] colour,
  input wire logic [fieldbus_pkg::HEALTH_W-1:0] health,
  // Indicator
  output logic [fieldbus_pkg::COLOUR_W-1:0] led_rgb
);
  logic [fieldbus_pkg::COLOUR_W-1:0] led_r;
  logic [fieldbus_pkg::COLOUR_W-1:0] led_nxt;

  always_comb begin
    case (ind_mode)
      fieldbus_pkg::IND_HEALTH: begin
        case (health)
          fieldbus_pkg::HEALTH_OK: led_nxt = fieldbus_pkg::LED_GREEN;
          fieldbus_pkg::HEALTH_MAINT: led_nxt = fieldbus_pkg::LED_BLUE;
          fieldbus_pkg::HEALTH_SPEC: led_nxt = fieldbus_pkg::LED_YELLOW;
          default: led_nxt = fieldbus_pkg::LED_RED;
        endcase
      end
      fieldbus_pkg::IND_FIXED: led_nxt = colour;
      fieldbus_pkg::IND_OFF: led_nxt = fieldbus_pkg::LED_DARK;
      default: led_nxt = fieldbus_pkg::LED_DARK;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_r <= fieldbus_pkg::LED_DARK;
    end else begin
      led_r <= led_nxt;
    end
  end

  assign led_rgb = led_r;
endmodule : status_indicator
`default_nettype wire

/* File: fieldbus_mode_dev.sv */
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module fieldbus_mode_dev #(
  parameter bit LARGE_CONNECTOR = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fieldbus_pkg::PADDR_W-1:0] paddr,
  input wire logic [fieldbus_pkg::DATA_W-1:0] pwdata,
  output logic [fieldbus_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fieldbus link
  fieldbus_link_if.dev link,
  // Device side
  input wire logic [fieldbus_pkg::HEALTH_W-1:0] health,
  input wire logic pdo_in_valid,
  input wire logic [fieldbus_pkg::DATA_W-1:0] pdo_in_data,
  output logic [fieldbus_pkg::COLOUR_W-1:0] led_rgb,
  output logic irq
);
  // Variant picks the power-up mode
  localparam fieldbus_pkg::bus_mode_t MODE_RESET =
    LARGE_CONNECTOR ? fieldbus_pkg::MODE_STANDALONE : fieldbus_pkg::MODE_VENDOR;
  localparam logic [fieldbus_pkg::IDX_W-1:0] DESC_LAST = fieldbus_pkg::IDX_W'(fieldbus_pkg::DESC_LEN - 1);

  // ****************************************
  // APB decode
  // ****************************************
  logic setup_rd;
  logic acc_wr;
  logic acc_rd;
  logic mapped;
  logic restart;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign acc_wr = psel & penable & pwrite;
  assign acc_rd = psel & penable & ~pwrite;
  assign restart = acc_wr & (paddr == fieldbus_pkg::OFF_CTRL) & pwdata[fieldbus_pkg::CTRL_RESTART_BIT];

  always_comb begin
    case (paddr)
      fieldbus_pkg::OFF_CTRL, fieldbus_pkg::OFF_CFG, fieldbus_pkg::OFF_UNAME, fieldbus_pkg::OFF_DESC_IDX,
      fieldbus_pkg::OFF_DESC_DATA, fieldbus_pkg::OFF_STATUS, fieldbus_pkg::OFF_IRQ_STAT,
      fieldbus_pkg::OFF_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // No wait states; the bus stays usable in every mode
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ****************************************
  // Configuration registers
  // ****************************************
  fieldbus_pkg::bus_mode_t mode_p_r, mode_p_nxt, mode_a_r, mode_a_nxt;
  fieldbus_pkg::ind_mode_t ind_r, ind_nxt;
  logic [fieldbus_pkg::RATE_W-1:0] rate_p_r, rate_p_nxt, rate_a_r, rate_a_nxt;
  logic [fieldbus_pkg::ADDR_W-1:0] addr_p_r, addr_p_nxt, addr_a_r, addr_a_nxt;
  logic [fieldbus_pkg::COLOUR_W-1:0] colour_r, colour_nxt;
  logic [fieldbus_pkg::DATA_W-1:0] uname_r, uname_nxt;
  logic [fieldbus_pkg::IDX_W-1:0] idx_r, idx_nxt;
  logic name_chg_r, name_chg_nxt;
  logic [fieldbus_pkg::MODE_W-1:0] w_mode;
  logic [fieldbus_pkg::IND_W-1:0] w_ind;
  logic [fieldbus_pkg::RATE_W-1:0] w_rate;
  logic desc_we;

  assign w_mode = pwdata[fieldbus_pkg::CFG_MODE_LSB +: fieldbus_pkg::MODE_W];
  assign w_ind = pwdata[fieldbus_pkg::CFG_IND_LSB +: fieldbus_pkg::IND_W];
  assign w_rate = pwdata[fieldbus_pkg::CFG_RATE_LSB +: fieldbus_pkg::RATE_W];
  assign desc_we = acc_wr & (paddr == fieldbus_pkg::OFF_DESC_DATA) & (idx_r <= DESC_LAST);

  always_comb begin
    mode_p_nxt = mode_p_r;
    rate_p_nxt = rate_p_r;
    addr_p_nxt = addr_p_r;
    ind_nxt = ind_r;
    colour_nxt = colour_r;
    uname_nxt = uname_r;
    idx_nxt = idx_r;
    name_chg_nxt = 1'b0;
    // Active settings move only on restart
    mode_a_nxt = restart ? mode_p_r : mode_a_r;
    rate_a_nxt = restart ? rate_p_r : rate_a_r;
    addr_a_nxt = restart ? addr_p_r : addr_a_r;
    if (acc_wr && paddr == fieldbus_pkg::OFF_CFG) begin
      // Unknown codes keep the old setting
      if (w_mode != 2'h3) begin
        mode_p_nxt = fieldbus_pkg::bus_mode_t'(w_mode);
      end
      if (w_rate <= fieldbus_pkg::RATE_1000K) begin
        rate_p_nxt = w_rate;
      end
      if (w_ind != 2'h3) begin
        ind_nxt = fieldbus_pkg::ind_mode_t'(w_ind);
      end
      addr_p_nxt = pwdata[fieldbus_pkg::CFG_ADDR_LSB +: fieldbus_pkg::ADDR_W];
      colour_nxt = pwdata[fieldbus_pkg::CFG_COLOUR_LSB +: fieldbus_pkg::COLOUR_W];
    end
    if (acc_wr && paddr == fieldbus_pkg::OFF_UNAME) begin
      uname_nxt = pwdata;
      name_chg_nxt = (pwdata != uname_r);
    end
    if (acc_wr && paddr == fieldbus_pkg::OFF_DESC_IDX) begin
      idx_nxt = pwdata[fieldbus_pkg::IDX_W-1:0];
    end else if (desc_we) begin
      idx_nxt = idx_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_p_r <= MODE_RESET;
      mode_a_r <= MODE_RESET;
      rate_p_r <= fieldbus_pkg::RATE_RESET;
      rate_a_r <= fieldbus_pkg::RATE_RESET;
      addr_p_r <= fieldbus_pkg::ADDR_RESET;
      addr_a_r <= fieldbus_pkg::ADDR_RESET;
      ind_r <= fieldbus_pkg::IND_HEALTH;
      colour_r <= fieldbus_pkg::COLOUR_RESET;
      uname_r <= fieldbus_pkg::UNAME_RESET;
      idx_r <= '0;
      name_chg_r <= 1'b0;
    end else begin
      mode_p_r <= mode_p_nxt;
      mode_a_r <= mode_a_nxt;
      rate_p_r <= rate_p_nxt;
      rate_a_r <= rate_a_nxt;
      addr_p_r <= addr_p_nxt;
      addr_a_r <= addr_a_nxt;
      ind_r <= ind_nxt;
      colour_r <= colour_nxt;
      uname_r <= uname_nxt;
      idx_r <= idx_nxt;
      name_chg_r <= name_chg_nxt;
    end
  end

  // ****************************************
  // Description store
  // ****************************************
  logic [fieldbus_pkg::CHAR_W-1:0] desc_r [fieldbus_pkg::DESC_LEN];

  for (genvar i = 0; i < fieldbus_pkg::DESC_LEN; i++) begin : g_desc
    logic [fieldbus_pkg::CHAR_W-1:0] char_nxt;
    always_comb begin
      char_nxt = (desc_we && idx_r == i) ? pwdata[fieldbus_pkg::CHAR_W-1:0] : desc_r[i];
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        desc_r[i] <= '0;
      end else begin
        desc_r[i] <= char_nxt;
      end
    end
  end

  // ****************************************
  // Network state and process data
  // ****************************************
  fieldbus_pkg::net_state_t net_r, net_nxt;
  logic lost_err;
  logic broken_r, broken_nxt;
  logic pdo_valid_r, pdo_valid_nxt;
  logic [fieldbus_pkg::DATA_W-1:0] pdo_data_r, pdo_data_nxt;

  // Standalone never flags a missing bus
  assign lost_err = (mode_a_r == fieldbus_pkg::MODE_VENDOR) & ~link.bus_present;

  always_comb begin
    net_nxt = net_r;
    if (restart) begin
      net_nxt = fieldbus_pkg::NET_PREOP;
    end else begin
      case (mode_a_r)
        fieldbus_pkg::MODE_VENDOR: net_nxt = fieldbus_pkg::NET_OPERATIONAL;
        fieldbus_pkg::MODE_CANOPEN: begin
          if (link.op_cmd) begin
            net_nxt = fieldbus_pkg::NET_OPERATIONAL;
          end
        end
        fieldbus_pkg::MODE_STANDALONE: net_nxt = fieldbus_pkg::NET_PREOP;
        default: net_nxt = fieldbus_pkg::NET_PREOP;
      endcase
    end
    // Relinking peers do not clear a fresh break
    broken_nxt = name_chg_r | (broken_r & ~link.relink);
    pdo_valid_nxt = pdo_in_valid & (net_r == fieldbus_pkg::NET_OPERATIONAL);
    pdo_data_nxt = pdo_valid_nxt ? pdo_in_data : pdo_data_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_r <= fieldbus_pkg::NET_PREOP;
      broken_r <= 1'b0;
      pdo_valid_r <= 1'b0;
      pdo_data_r <= '0;
    end else begin
      net_r <= net_nxt;
      broken_r <= broken_nxt;
      pdo_valid_r <= pdo_valid_nxt;
      pdo_data_r <= pdo_data_nxt;
    end
  end

  assign link.dev_rate = rate_a_r;
  assign link.dev_addr = addr_a_r;
  assign link.dev_operational = (net_r == fieldbus_pkg::NET_OPERATIONAL);
  assign link.name_chg = name_chg_r;
  assign link.pdo_valid = pdo_valid_r;
  assign link.pdo_data = pdo_data_r;

  // ****************************************
  // Interrupts and read data
  // ****************************************
  logic [fieldbus_pkg::IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt, events;
  logic [fieldbus_pkg::DATA_W-1:0] rdata_r, rdata_nxt, status;

  always_comb begin
    status = '0;
    status[fieldbus_pkg::CFG_MODE_LSB +: fieldbus_pkg::MODE_W] = mode_a_r;
    status[fieldbus_pkg::CFG_RATE_LSB +: fieldbus_pkg::RATE_W] = rate_a_r;
    status[fieldbus_pkg::CFG_ADDR_LSB +: fieldbus_pkg::ADDR_W] = addr_a_r;
    status[fieldbus_pkg::ST_OPER_BIT] = (net_r == fieldbus_pkg::NET_OPERATIONAL);
    status[fieldbus_pkg::ST_PDO_BIT] = (net_r == fieldbus_pkg::NET_OPERATIONAL);
    status[fieldbus_pkg::ST_LOST_BIT] = lost_err;
    status[fieldbus_pkg::ST_BROKEN_BIT] = broken_r;
    events = '0;
    events[fieldbus_pkg::IRQ_LOST] = lost_err;
    events[fieldbus_pkg::IRQ_NAME] = name_chg_r;
    events[fieldbus_pkg::IRQ_OPER] = (net_nxt == fieldbus_pkg::NET_OPERATIONAL) &
                                     (net_r == fieldbus_pkg::NET_PREOP);
    // Only bits already returned are cleared, so a new event wins
    ist_nxt = ist_r | events;
    if (acc_rd && paddr == fieldbus_pkg::OFF_IRQ_STAT) begin
      ist_nxt = (ist_r & ~rdata_r[fieldbus_pkg::IRQ_W-1:0]) | events;
    end
    imask_nxt = (acc_wr && paddr == fieldbus_pkg::OFF_IRQ_MASK) ? pwdata[fieldbus_pkg::IRQ_W-1:0] : imask_r;
    rdata_nxt = rdata_r;
    if (setup_rd) begin
      rdata_nxt = '0;
      case (paddr)
        fieldbus_pkg::OFF_CFG: begin
          rdata_nxt[fieldbus_pkg::CFG_MODE_LSB +: fieldbus_pkg::MODE_W] = mode_p_r;
          rdata_nxt[fieldbus_pkg::CFG_RATE_LSB +: fieldbus_pkg::RATE_W] = rate_p_r;
          rdata_nxt[fieldbus_pkg::CFG_ADDR_LSB +: fieldbus_pkg::ADDR_W] = addr_p_r;
          rdata_nxt[fieldbus_pkg::CFG_IND_LSB +: fieldbus_pkg::IND_W] = ind_r;
          rdata_nxt[fieldbus_pkg::CFG_COLOUR_LSB +: fieldbus_pkg::COLOUR_W] = colour_r;
        end
        fieldbus_pkg::OFF_UNAME: rdata_nxt = uname_r;
        fieldbus_pkg::OFF_DESC_IDX: rdata_nxt[fieldbus_pkg::IDX_W-1:0] = idx_r;
        fieldbus_pkg::OFF_DESC_DATA: begin
          if (idx_r <= DESC_LAST) begin
            rdata_nxt[fieldbus_pkg::CHAR_W-1:0] = desc_r[idx_r];
          end
        end
        fieldbus_pkg::OFF_STATUS: rdata_nxt = status;
        fieldbus_pkg::OFF_IRQ_STAT: rdata_nxt[fieldbus_pkg::IRQ_W-1:0] = ist_r;
        fieldbus_pkg::OFF_IRQ_MASK: rdata_nxt[fieldbus_pkg::IRQ_W-1:0] = imask_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= '0;
      imask_r <= '0;
      rdata_r <= '0;
    end else begin
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign prdata = rdata_r;
  assign irq = |(ist_r & imask_r);

  status_indicator u_indicator (
    .pclk(pclk),
    .presetn(presetn),
    .ind_mode(ind_r),
    .colour(colour_r),
    .health(health),
    .led_rgb(led_rgb)
  );
endmodule : fieldbus_mode_dev
`default_nettype wire

/* File: fieldbus_master_end.sv */
`timescale 1ns/100ps
`default_nettype none
module fieldbus_master_end (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fieldbus link
  fieldbus_link_if.master link,
  // Network user side
  input wire logic connect,
  input wire logic start_op,
  input wire logic [fieldbus_pkg::RATE_W-1:0] host_rate,
  input wire logic [fieldbus_pkg::ADDR_W-1:0] peer_addr,
  output logic link_up,
  output logic rate_mismatch,
  output logic addr_clash,
  output logic pdo_seen,
  output logic [fieldbus_pkg::DATA_W-1:0] pdo_out
);
  fieldbus_pkg::link_state_t st_r, st_nxt;
  logic op_r, op_nxt, relink_r, relink_nxt, mis_r, mis_nxt, clash_r, clash_nxt, seen_r, seen_nxt;
  logic [fieldbus_pkg::DATA_W-1:0] pdo_r, pdo_nxt;

  always_comb begin
    st_nxt = st_r;
    relink_nxt = 1'b0;
    case (st_r)
      fieldbus_pkg::LINK_DOWN: if (connect) st_nxt = fieldbus_pkg::LINK_UP;
      fieldbus_pkg::LINK_UP: begin
        if (!connect) begin
          st_nxt = fieldbus_pkg::LINK_DOWN;
        end else if (link.name_chg) begin
          st_nxt = fieldbus_pkg::LINK_RESTORE;
        end
      end
      fieldbus_pkg::LINK_RESTORE: begin
        st_nxt = connect ? fieldbus_pkg::LINK_UP : fieldbus_pkg::LINK_DOWN;
        relink_nxt = connect;
      end
      default: st_nxt = fieldbus_pkg::LINK_DOWN;
    endcase
    mis_nxt = (host_rate != link.dev_rate);
    clash_nxt = (peer_addr == link.dev_addr);
    // Command only a reachable, consistently set node
    op_nxt = start_op & (st_r == fieldbus_pkg::LINK_UP) & ~mis_r & ~clash_r;
    seen_nxt = link.pdo_valid & (st_r == fieldbus_pkg::LINK_UP);
    pdo_nxt = seen_nxt ? link.pdo_data : pdo_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= fieldbus_pkg::LINK_DOWN;
      op_r <= 1'b0;
      relink_r <= 1'b0;
      mis_r <= 1'b0;
      clash_r <= 1'b0;
      seen_r <= 1'b0;
      pdo_r <= '0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      relink_r <= relink_nxt;
      mis_r <= mis_nxt;
      clash_r <= clash_nxt;
      seen_r <= seen_nxt;
      pdo_r <= pdo_nxt;
    end
  end

  assign link.bus_present = (st_r != fieldbus_pkg::LINK_DOWN);
  assign link.op_cmd = op_r;
  assign link.relink = relink_r;
  assign link_up = (st_r == fieldbus_pkg::LINK_UP);
  assign rate_mismatch = mis_r;
  assign addr_clash = clash_r;
  assign pdo_seen = seen_r;
  assign pdo_out = pdo_r;
endmodule : fieldbus_master_end
`default_nettype wire

/* File: fieldbus_props.sv */
`timescale 1ns/100ps
`default_nettype none
module fieldbus_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link signals
  input wire logic bus_present,
  input wire logic op_cmd,
  input wire logic relink,
  input wire logic [fieldbus_pkg::RATE_W-1:0] dev_rate,
  input wire logic [fieldbus_pkg::ADDR_W-1:0] dev_addr,
  input wire logic dev_operational,
  input wire logic name_chg,
  input wire logic pdo_valid,
  input wire logic [fieldbus_pkg::DATA_W-1:0] pdo_data
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_rate_default: assert property ($rose(presetn) |-> dev_rate == fieldbus_pkg::RATE_RESET)
    else $error("bit rate not at default after reset");
  chk_addr_default: assert property ($rose(presetn) |-> dev_addr == fieldbus_pkg::ADDR_RESET)
    else $error("node address not at default after reset");
  chk_rate_restart: assert property (!$stable(dev_rate) |-> !dev_operational)
    else $error("bit rate changed outside a restart");
  chk_addr_restart: assert property (!$stable(dev_addr) |-> !dev_operational)
    else $error("node address changed outside a restart");
  chk_pdo_oper: assert property (pdo_valid |-> $past(dev_operational))
    else $error("process data sent while not operational");
  chk_pdo_hold: assert property (!pdo_valid |-> $stable(pdo_data))
    else $error("process data changed without a valid pulse");
  chk_name_pulse: assert property (name_chg |=> !name_chg)
    else $error("name change pulse too long");
  chk_relink_after: assert property (name_chg && bus_present |-> ##[1:3] relink)
    else $error("no relink after name change");
  chk_op_pulse: assert property (op_cmd |=> !op_cmd)
    else $error("operational command not a single pulse");
endmodule : fieldbus_props
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, connect = 1'b0, start_op = 1'b0, pdo_in_valid = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, pdo_in_data = 32'h0, prdata, pdo_out, r, pdo_got = 32'h0;
  logic pready, pslverr, perr, irq, link_up, rate_mismatch, addr_clash, pdo_seen, name_seen = 1'b0;
  logic [1:0] health = 2'h1;
  logic [2:0] host_rate = 3'h2, led_rgb;
  logic [6:0] peer_addr = 7'h07;
  int bad_count = 0, check_count = 0, pdo_cnt = 0;
  fieldbus_link_if link ();
  always #12.5 pclk = ~pclk;
  fieldbus_mode_dev i_fieldbus_mode_dev (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link), .health(health), .pdo_in_valid(pdo_in_valid), .pdo_in_data(pdo_in_data),
    .led_rgb(led_rgb), .irq(irq));
  fieldbus_master_end i_fieldbus_master_end (.pclk(pclk), .presetn(presetn), .link(link), .connect(connect),
    .start_op(start_op), .host_rate(host_rate), .peer_addr(peer_addr), .link_up(link_up),
    .rate_mismatch(rate_mismatch), .addr_clash(addr_clash), .pdo_seen(pdo_seen), .pdo_out(pdo_out));
  fieldbus_props i_props (.pclk(pclk), .presetn(presetn), .bus_present(link.bus_present), .op_cmd(link.op_cmd),
    .relink(link.relink), .dev_rate(link.dev_rate), .dev_addr(link.dev_addr),
    .dev_operational(link.dev_operational), .name_chg(link.name_chg), .pdo_valid(link.pdo_valid),
    .pdo_data(link.pdo_data));
  always @(posedge pclk) begin
    if (link.name_chg) name_seen <= 1'b1;
    if (pdo_seen) begin
      pdo_cnt <= pdo_cnt + 1;
      pdo_got <= pdo_out;
    end
  end
  // ****************************************
  // Helpers
  // ****************************************
  task wt(input int n); repeat (n) @(posedge pclk); endtask : wt
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Zero-wait slave, but the master still waits on pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] cfg(input logic [1:0] m, input logic [2:0] rt, input logic [6:0] ad,
    input logic [1:0] ind, input logic [2:0] col);
    return {9'h0, col, 2'h0, ind, 1'b0, ad, 1'b0, rt, 2'h0, m};
  endfunction : cfg
  task st(input logic [1:0] m, input logic [2:0] rt, input logic [6:0] ad, input logic op);
    apb(1'b0, fieldbus_pkg::OFF_STATUS, 32'h0);
    chk({r[16], r[14:8], r[6:4], r[1:0]}, {op, ad, rt, m});
  endtask : st
  // Extra cycles let the new mode's state settle before reading it
  task restart; apb(1'b1, fieldbus_pkg::OFF_CTRL, 32'h1); wt(2); endtask : restart
  task pulse_op; @(posedge pclk); start_op <= 1'b1; @(posedge pclk); start_op <= 1'b0; wt(3); endtask : pulse_op
  task pdo_send(input logic [31:0] d);
    @(posedge pclk); pdo_in_valid <= 1'b1; pdo_in_data <= d;
    @(posedge pclk); pdo_in_valid <= 1'b0; wt(4);
  endtask : pdo_send
  // ****************************************
  // Scenarios
  // ****************************************
  task t_defaults;
    st(2'h0, 3'h2, 7'h1e, 1'b0);
    chk(r[18], 1'b0);
    chk(led_rgb, fieldbus_pkg::LED_BLUE);
    apb(1'b0, 8'h40, 32'h0); chk({31'h0, perr}, 32'h1);
    chk(r, 32'h0);
  endtask : t_defaults
  task t_ind;
    apb(1'b1, fieldbus_pkg::OFF_CFG, cfg(2'h0, 3'h2, 7'h1e, 2'h1, fieldbus_pkg::LED_RED)); wt(2);
    health <= fieldbus_pkg::HEALTH_SPEC; wt(2); chk(led_rgb, fieldbus_pkg::LED_RED);
    apb(1'b1, fieldbus_pkg::OFF_CFG, cfg(2'h0, 3'h2, 7'h1e, 2'h2, 3'h2)); wt(2); chk(led_rgb, 3'h0);
    apb(1'b1, fieldbus_pkg::OFF_CFG, cfg(2'h0, 3'h2, 7'h1e, 2'h0, 3'h2)); wt(2);
    chk(led_rgb, fieldbus_pkg::LED_YELLOW);
    // Unused codes must leave mode, rate and indicator as they were
    apb(1'b1, fieldbus_pkg::OFF_CFG, cfg(2'h3, 3'h7, 7'h1e, 2'h3, 3'h2));
    apb(1'b0, fieldbus_pkg::OFF_CFG, 32'h0); chk(r, cfg(2'h0, 3'h2, 7'h1e, 2'h0, 3'h2));
  endtask : t_ind
  task t_vendor;
    apb(1'b1, fieldbus_pkg::OFF_CFG, cfg(2'h1, 3'h1, 7'h1e, 2'h0, 3'h2));
    st(2'h0, 3'h2, 7'h1e, 1'b0);
    restart; st(2'h1, 3'h1, 7'h1e, 1'b1);
    chk(r[18], 1'b1);
    apb(1'b1, fieldbus_pkg::OFF_IRQ_MASK, 32'h1); wt(1); chk(irq, 1'b1);
    connect <= 1'b1; host_rate <= 3'h1; wt(4);
    apb(1'b0, fieldbus_pkg::OFF_IRQ_STAT, 32'h0); apb(1'b0, fieldbus_pkg::OFF_IRQ_STAT, 32'h0);
    chk({r[0], irq}, 2'b00);
    pdo_send(32'ha5c30f1e); chk(pdo_got, 32'ha5c30f1e);
  endtask : t_vendor
  task t_name;
    apb(1'b1, fieldbus_pkg::OFF_UNAME, 32'h1234abcd); wt(6); chk(name_seen, 1'b1);
    apb(1'b0, fieldbus_pkg::OFF_IRQ_STAT, 32'h0); chk(r[1], 1'b1);
    apb(1'b0, fieldbus_pkg::OFF_STATUS, 32'h0); chk({r[19], link_up}, 2'b01);
  endtask : t_name
  task t_desc;
    apb(1'b1, fieldbus_pkg::OFF_DESC_IDX, 32'd18); apb(1'b1, fieldbus_pkg::OFF_DESC_DATA, 32'h41);
    apb(1'b1, fieldbus_pkg::OFF_DESC_DATA, 32'h42); apb(1'b1, fieldbus_pkg::OFF_DESC_IDX, 32'd18);
    apb(1'b0, fieldbus_pkg::OFF_DESC_DATA, 32'h0); chk(r, 32'h41);
    apb(1'b1, fieldbus_pkg::OFF_DESC_IDX, 32'd19);
    apb(1'b0, fieldbus_pkg::OFF_DESC_DATA, 32'h0); chk(r, 32'h0);
  endtask : t_desc
  task t_canopen;
    host_rate <= 3'h0;
    apb(1'b1, fieldbus_pkg::OFF_CFG, cfg(2'h2, 3'h1, 7'h05, 2'h0, 3'h2));
    restart; st(2'h2, 3'h1, 7'h05, 1'b0);
    wt(2); chk(rate_mismatch, 1'b1);
    peer_addr <= 7'h05; host_rate <= 3'h1; wt(3);
    chk({rate_mismatch, addr_clash}, 2'b01);
    pulse_op; chk(link.dev_operational, 1'b0);
    peer_addr <= 7'h07; wt(3); pulse_op; chk(link.dev_operational, 1'b1);
    apb(1'b1, fieldbus_pkg::OFF_CFG, cfg(2'h0, 3'h2, 7'h1e, 2'h0, 3'h2));
    restart; st(2'h0, 3'h2, 7'h1e, 1'b0);
    pdo_send(32'h0badf00d); chk(pdo_cnt, 32'd1);
  endtask : t_canopen
  task end_sim;
    $display("Checks %0d, errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial begin
    wt(2);
    presetn <= 1'b1;
    t_defaults;
    t_ind;
    t_vendor;
    t_name;
    t_desc;
    t_canopen;
    end_sim;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    wt(4000);
    bad_count++;
    end_sim;
  end
endmodule : testbench
`default_nettype wire
